// File: dv/cfts_card_model.sv
// Purpose: Card side receiver that records the bits of each frame.
// Assumes: One bit lasts BIT_DIV clocks and starts with rf_enable.
// Notes:   Samples mid-bit so an edge race never decides a bit.
`timescale 1ns/1ps
`default_nettype none
module cfts_card_model #(
	parameter int BIT_DIV = 4  // Clocks per RF bit.
) (
	input wire logic    clk,       // Device clock.
	input wire logic    sys_rst,   // Synchronous reset.
	input wire logic    rf_data,   // Serial RF bit.
	input wire logic    rf_enable, // Frame on air.
	output logic [63:0] bits,      // Bits seen, first at index 0.
	output int          nbits      // Count of bits seen.
);
	logic prev;  // Enable one cycle back.
	int   cnt;   // Cycle within the bit.

	// A rising enable opens a new record; each bit is taken at its middle.
	always_ff @(posedge clk) begin
		prev <= rf_enable;
		cnt  <= (!rf_enable || cnt == BIT_DIV - 1) ? 0 : cnt + 1;
		if (sys_rst || (rf_enable && !prev))
			nbits <= 0;
		if (rf_enable && cnt == BIT_DIV / 2) begin
			bits[nbits[5:0]] <= rf_data;
			nbits            <= nbits + 1;
		end
	end
endmodule
`default_nettype wire

// File: dv/cfts_sva.sv
// Purpose: Port checks for the transmit sequencer.
// Assumes: BIT_DIV equals the value the design instance uses.
// Notes:   Sees only the top ports; bound below.
`timescale 1ns/1ps
`default_nettype none
module cfts_sva
	import cfts_pkg::*;
#(
	parameter int BIT_DIV = 4  // Clocks per RF bit.
) (
	input wire logic       clk,       // Device clock.
	input wire logic       sys_rst,   // Synchronous reset.
	input wire cfts_bus_t  bus,       // Host request.
	input wire logic [7:0] rd_data,   // Read answer.
	input wire logic       rf_data,   // Serial RF bit.
	input wire logic       rf_enable  // Frame on air.
);
	// ****************
	// Helpers
	// ****************
	int         ph;  // Cycle within the current bit.
	wire logic  stop_wr = bus.wr && bus.addr == OFS_COMMAND && bus.wdata != CMD_TRANSMIT;
	wire logic  st_rd   = bus.rd && bus.addr == OFS_STATUS;

	// Restarts with every frame, so the hold check stays aligned to bit edges.
	always_ff @(posedge clk) begin
		if (sys_rst || !rf_enable)
			ph <= 0;
		else
			ph <= (ph == BIT_DIV - 1) ? 0 : ph + 1;
	end

	// ****************
	// Assertions
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Read data only ever stands in the cycle after a read.
	chk_read_idle: assert property (!$past(bus.rd) |-> rd_data == 8'h00)
		else $error("read data not zero outside a read answer");
	chk_abort_halt: assert property (stop_wr && rf_enable |=> !rf_enable && !rf_data)
		else $error("transmit did not halt after command overwrite");
	chk_abort_quiet: assert property (stop_wr && rf_enable |=> !rf_enable [*4])
		else $error("transmit resumed after cancel");
	chk_rf_quiet: assert property (!rf_enable |-> !rf_data)
		else $error("rf data high outside a frame");
	chk_sof_first: assert property ($rose(rf_enable) |-> rf_data)
		else $error("frame did not open with the start bit");
	chk_bit_hold: assert property (rf_enable && ph != 0 |-> $stable(rf_data))
		else $error("rf bit changed inside a bit period");
	chk_eof_tail: assert property ($fell(rf_enable) && !$past(bus.wr) |-> !$past(rf_data))
		else $error("frame ended without end pattern");
	chk_phase_air: assert property (st_rd && rf_enable |=>
		rd_data[6:4] inside {3'b010, 3'b011, 3'b100, 3'b110})
		else $error("modem phase idle while frame on air");
endmodule
bind cfts_top cfts_sva #(.BIT_DIV(BIT_DIV)) u_sva (
	.clk(clk),
	.sys_rst(sys_rst),
	.bus(bus),
	.rd_data(rd_data),
	.rf_data(rf_data),
	.rf_enable(rf_enable)
);
`default_nettype wire

// File: dv/test_card_frame_transmit_sequencer.sv
// Purpose: Register driven frame tests of the transmit sequencer.
// Assumes: BIT_DIV shortened to 4 clocks per bit.
// Notes:   Frames are compared bit by bit against a locally built image.
`timescale 1ns/1ps
`default_nettype none
module test_card_frame_transmit_sequencer
	import cfts_pkg::*;
;
	localparam int B = 4;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	cfts_bus_t   bus = '0;
	logic [7:0]  rd_data, d;
	logic        rf_data, rf_enable;
	logic [63:0] bits, exp;
	logic [15:0] c16;
	int          nbits, xn, n_mismatch, num_checks;

	always #10 clk = ~clk;

	cfts_top #(.BIT_DIV(B), .DEPTH(FIFO_DEPTH)) dut (
		.clk(clk), .sys_rst(sys_rst), .bus(bus),
		.rd_data(rd_data), .rf_data(rf_data), .rf_enable(rf_enable));
	cfts_card_model #(.BIT_DIV(B)) card (
		.clk(clk), .sys_rst(sys_rst), .rf_data(rf_data),
		.rf_enable(rf_enable), .bits(bits), .nbits(nbits));

	// ****************
	// Bus and compare tasks
	// ****************
	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// The answer is taken just after the edge that opens its only valid cycle.
	task automatic rchk(input string nm, input logic [5:0] a, input logic [7:0] e);
		@(posedge clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		bus <= '0;
		#1 d = rd_data;
		chk(nm, e, d);
	endtask
	task automatic put(input logic b);
		exp[xn] = b;
		xn++;
	endtask
	task automatic sof();
		exp = '0;
		xn  = 0;
		put(1'b1);
	endtask
	task automatic put_byte(input logic [7:0] v, input int n, input logic par, input logic odd);
		for (int i = 0; i < n; i++)
			put(v[i]);
		if (par)
			put(^v ^ odd);
	endtask
	// Waits for a whole frame under a bound, then compares it with the image.
	task automatic frame(input string nm);
		for (int i = 0; i < 4000 && !rf_enable; i++)
			@(negedge clk);
		for (int i = 0; i < 4000 && rf_enable; i++)
			@(negedge clk);
		put(1'b0);
		put(1'b0);
		chk(nm, exp & ((64'h1 << xn) - 1), bits & ((64'h1 << xn) - 1));
		chk(nm, 64'(xn), 64'(nbits));
	endtask
	function automatic logic [15:0] crc16(input logic [7:0] v);
		logic [15:0] c;
		c = CRC16_PRESET ^ {8'h00, v};
		for (int i = 0; i < 8; i++)
			c = c[0] ? (c >> 1) ^ CRC16_POLY : c >> 1;
		return c;
	endfunction
	task automatic summarize();
		$display("TB: checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Cuts a hang short; the whole sequence needs far fewer cycles.
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		summarize();
	end

	// ****************
	// Tests
	// ****************
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		wr(6'h3E, 8'hFF);
		rchk("redundancy", OFS_REDUND, REDUND_RST);
		rchk("framing", OFS_FRAMING, FRAMING_RST);
		rchk("command", OFS_COMMAND, CMD_IDLE);
		rchk("status", OFS_STATUS, 8'h01);
		rchk("unmapped", 6'h3E, 8'h00);
		$display("TB: reset values done");
		// Default setup: even parity and a two byte check value.
		wr(OFS_FIFO_PORT, 8'hA5);
		wr(OFS_COMMAND, CMD_TRANSMIT);
		c16 = crc16(8'hA5);
		sof();
		put_byte(8'hA5, 8, 1'b1, 1'b0);
		put_byte(c16[7:0], 8, 1'b1, 1'b0);
		put_byte(c16[15:8], 8, 1'b1, 1'b0);
		frame("crc frame");
		rchk("flags", OFS_FLAGS, 8'h03);
		rchk("cmd after", OFS_COMMAND, CMD_IDLE);
		rchk("level", OFS_FIFO_LEVEL, 8'h00);
		wr(OFS_FLAGS, 8'h03);
		rchk("flags clr", OFS_FLAGS, 8'h00);
		$display("TB: crc frame done");
		// Check value without parity: the last data bit must still be folded in.
		wr(OFS_REDUND, 8'h01);
		wr(OFS_FIFO_PORT, 8'h3C);
		wr(OFS_COMMAND, CMD_TRANSMIT);
		c16 = crc16(8'h3C);
		sof();
		put_byte(8'h3C, 8, 1'b0, 1'b0);
		put_byte(c16[7:0], 8, 1'b0, 1'b0);
		put_byte(c16[15:8], 8, 1'b0, 1'b0);
		frame("crc no parity");
		$display("TB: crc no parity done");
		// Odd parity with a byte appended while sending.
		wr(OFS_REDUND, 8'h06);
		wr(OFS_FIFO_PORT, 8'h03);
		wr(OFS_COMMAND, CMD_TRANSMIT);
		wr(OFS_FIFO_PORT, 8'hFE);
		sof();
		put_byte(8'h03, 8, 1'b1, 1'b1);
		put_byte(8'hFE, 8, 1'b1, 1'b1);
		frame("odd parity");
		$display("TB: append done");
		// Truncated final byte: no parity on it, count clears itself.
		wr(OFS_REDUND, 8'h02);
		wr(OFS_FRAMING, 8'h04);
		wr(OFS_FIFO_PORT, 8'h3C);
		wr(OFS_FIFO_PORT, 8'h81);
		wr(OFS_COMMAND, CMD_TRANSMIT);
		sof();
		put_byte(8'h3C, 8, 1'b1, 1'b0);
		put_byte(8'h81, 4, 1'b0, 1'b0);
		frame("short byte");
		rchk("framing clr", OFS_FRAMING, 8'h00);
		$display("TB: short byte done");
		// A byte written after the last check stays behind.
		wr(OFS_REDUND, 8'h00);
		wr(OFS_FIFO_PORT, 8'h5A);
		wr(OFS_COMMAND, CMD_TRANSMIT);
		// The bit count of the previous frame stands until this frame is on air.
		for (int i = 0; i < 500 && !(rf_enable && nbits == 9); i++)
			@(negedge clk);
		wr(OFS_FIFO_PORT, 8'h77);
		sof();
		put_byte(8'h5A, 8, 1'b0, 1'b0);
		frame("late write");
		rchk("kept level", OFS_FIFO_LEVEL, 8'h01);
		rchk("kept byte", OFS_FIFO_PORT, 8'h77);
		$display("TB: late write done");
		// Armed with an empty FIFO: nothing moves until a byte lands.
		wr(OFS_COMMAND, CMD_TRANSMIT);
		repeat (20) @(negedge clk);
		chk("armed quiet", 64'h0, 64'(rf_enable));
		rchk("armed status", OFS_STATUS, 8'h15);
		wr(OFS_FIFO_PORT, 8'hC3);
		sof();
		put_byte(8'hC3, 8, 1'b0, 1'b0);
		frame("armed");
		wr(OFS_FLAGS, 8'h03);
		$display("TB: armed start done");
		// Cancel in mid-byte: no flags, queued byte kept.
		wr(OFS_FIFO_PORT, 8'h11);
		wr(OFS_FIFO_PORT, 8'h22);
		wr(OFS_COMMAND, CMD_TRANSMIT);
		for (int i = 0; i < 100 && !rf_enable; i++)
			@(negedge clk);
		repeat (5 * B) @(negedge clk);
		rchk("air status", OFS_STATUS, 8'h34);
		wr(OFS_COMMAND, CMD_IDLE);
		repeat (2) @(negedge clk);
		chk("abort off", 64'h0, 64'(rf_enable));
		rchk("abort flags", OFS_FLAGS, 8'h00);
		rchk("abort level", OFS_FIFO_LEVEL, 8'h01);
		rchk("abort byte", OFS_FIFO_PORT, 8'h22);
		$display("TB: cancel done");
		summarize();
	end
endmodule
`default_nettype wire

// File: hdl/cfts_pkg.sv
// Purpose: Shared constants and types for the card frame transmit sequencer.
// Assumes: 50 MHz device clock, 8-bit register port with 6-bit addresses.
// Notes:   Offsets, field layouts, reset values, states and timing live here only.
`default_nettype none
package cfts_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ      = 50_000_000;
	localparam int BIT_TIME_NS = 9440;
	// One RF bit period in device clock cycles, rounded down.
	localparam int BIT_CYCLES  = (BIT_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;

	// ************************************************************
	// Sizes, commands and register offsets
	// ************************************************************
	localparam int         FIFO_DEPTH     = 64;
	localparam logic [7:0] CMD_IDLE       = 8'h00;
	localparam logic [7:0] CMD_TRANSMIT   = 8'h1A;
	localparam logic [5:0] OFS_STATUS     = 6'h03;
	localparam logic [5:0] OFS_FIFO_PORT  = 6'h02;
	localparam logic [5:0] OFS_FIFO_LEVEL = 6'h04;
	localparam logic [5:0] OFS_FLAGS      = 6'h07;
	localparam logic [5:0] OFS_COMMAND    = 6'h01;
	localparam logic [5:0] OFS_FRAMING    = 6'h0F;
	localparam logic [5:0] OFS_REDUND     = 6'h22;
	localparam logic [7:0] REDUND_RST     = 8'h03;
	localparam logic [7:0] FRAMING_RST    = 8'h00;
	localparam logic [7:0] READ_ZERO      = 8'h00;

	// ************************************************************
	// Frame shape and redundancy
	// ************************************************************
	localparam logic [3:0]  SOF_LAST     = 4'h0;
	localparam logic [3:0]  EOF_BITS     = 4'h2;
	localparam logic        SOF_LEVEL    = 1'b1;
	localparam logic        EOF_LEVEL    = 1'b0;
	localparam logic [3:0]  LAST_FULL    = 4'h7;
	localparam logic [3:0]  CHK_PARITY   = 4'h7;
	localparam logic [3:0]  CHK_NOPARITY = 4'h6;
	localparam logic [15:0] CRC16_PRESET = 16'h6363;
	localparam logic [15:0] CRC16_POLY   = 16'h8408;
	localparam logic [7:0]  CRC8_PRESET  = 8'hFF;
	localparam logic [7:0]  CRC8_POLY    = 8'hB8;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAIT = 3'b001,
		ST_SOF  = 3'b010,
		ST_DATA = 3'b011,
		ST_PAR  = 3'b100,
		ST_EOF  = 3'b110
	} cfts_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} cfts_bus_t;

	typedef struct packed {
		logic [3:0] rsvd;
		logic       crc8;
		logic       parity_odd_select;
		logic       parity_enable;
		logic       tx_crc_enable;
	} cfts_redund_t;

	typedef struct packed {
		logic [4:0] rsvd;
		logic [2:0] tx_last_bit_count;
	} cfts_framing_t;

	typedef struct packed {
		logic       rsvd7;
		logic [2:0] modem_phase;
		logic       rsvd3;
		logic       busy;
		logic       fifo_full;
		logic       fifo_empty;
	} cfts_status_t;

	typedef struct packed {
		logic [5:0] rsvd;
		logic       idle_done_flag;
		logic       tx_done_flag;
	} cfts_flags_t;

endpackage
`default_nettype wire

// File: hdl/cfts_top.sv
// Purpose: Transmit sequencer that frames FIFO bytes into a serial RF bit stream.
// Assumes: Host port strobes are one cycle long and synchronous to clk.
// Notes:   Only the transmit command is served; other codes stop the sequencer.
//
// Behaviour
// [R1] Command 1Ah moves FIFO bytes to the transmitter and returns nothing.
// [R2] Transmit starts only through a host write of the command register.
// [R3] Host may preload up to 64 bytes while idle, then launch.
// [R4] Launch with empty FIFO arms; sending begins when a byte arrives.
// [R5] Host keeps the FIFO fed in time for a gap-free stream.
// [R6] Bytes written during transmit are appended after queued bytes.
// [R7] Needing a byte with FIFO empty ends transmit and returns to idle.
// [R8] Frame completion sets the transmit-done flag.
// [R9] Another command written during transmit halts sending next clock.
// [R10] Each frame is start pattern, data, then end pattern.
// [R11] Current phase is readable as a 3-bit modem phase field.
// [R12] With CRC enabled a CRC over the data is appended.
// [R13] Parity only when enabled, odd or even by the select bit.
// [R14] Nonzero last bit count sends that many low bits of final byte.
// [R15] Full bytes get parity; a truncated final byte gets none.
// [R16] Last bit count clears itself after a completed transmission.
// [R17] Host clears CRC enable whenever last bit count is nonzero.
// [R18] While accept-more is high, new bytes join the current frame.
// [R19] Accept-more low ends the frame; later bytes stay in the FIFO.
// [R20] Parity pushes the accept-more decision back by one bit.
// [R21] Only the empty check, one bit before the last, changes accept-more.
// [R22] A write just before the check keeps accept-more high.
// [R23] Writing idle cancels, keeps the FIFO, raises no idle flag.
// [R24] Self-finished command returns to idle and sets the idle-done flag.
// [R25] One bit-period enable paces bits, parity and the empty check.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cfts_top
	import cfts_pkg::*;
#(
	parameter int BIT_DIV = BIT_CYCLES,  // Clock cycles per RF bit.
	parameter int DEPTH   = FIFO_DEPTH   // FIFO depth in bytes.
) (
	input  wire logic      clk,      // Device clock, 50 MHz.
	input  wire logic      sys_rst,  // Synchronous reset, active high.
	input  wire cfts_bus_t bus,      // Host register request.
	output logic [7:0]     rd_data,  // Read answer, one cycle after the strobe.
	output logic           rf_data,  // Serial bit towards the RF transmitter.
	output logic           rf_enable // High while a frame is on the air.
);

	localparam int AW = $clog2(DEPTH);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (BIT_DIV < 2 || BIT_DIV > 65535) begin : g_bad_div
		$error("BIT_DIV must lie between 2 and 65535.");
	end
	if (DEPTH < 2 || (1 << AW) != DEPTH || DEPTH > 128) begin : g_bad_depth
		$error("DEPTH must be a power of two between 2 and 128.");
	end

	localparam logic [15:0] DIV_LAST = 16'(BIT_DIV - 1);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

	// ************************************************************
	// State
	// ************************************************************
	cfts_state_t   state;
	cfts_state_t   next_state;
	cfts_redund_t  redundancy_config;
	cfts_framing_t bit_framing_config;
	cfts_flags_t   flags;
	cfts_status_t  main_status_reg;
	logic [7:0]    command;
	logic [7:0]    fifo_mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   fifo_count;
	logic [15:0]   div_cnt;
	logic [3:0]    pos;
	logic [3:0]    next_pos;
	logic [7:0]    cur_byte;
	logic [15:0]   crc;
	logic          from_crc;
	logic          crc_hi_pend;
	logic          final_short;
	logic          accept_more;

	// ************************************************************
	// Register decode
	// ************************************************************
	wire wr_cmd    = bus.wr && bus.addr == OFS_COMMAND;
	wire wr_fifo   = bus.wr && bus.addr == OFS_FIFO_PORT;
	wire wr_redund = bus.wr && bus.addr == OFS_REDUND;
	wire wr_frm    = bus.wr && bus.addr == OFS_FRAMING;
	wire wr_flags  = bus.wr && bus.addr == OFS_FLAGS;
	wire rd_fifo   = bus.rd && bus.addr == OFS_FIFO_PORT;

	// FIFO status and the two sources of pops.
	wire fifo_empty = fifo_count == '0;
	wire fifo_full  = fifo_count == FULL_CNT;
	wire push       = wr_fifo && !fifo_full;
	wire tx_busy    = state != ST_IDLE;
	// Host reads never drain a byte the transmitter may still claim.
	wire host_pop   = rd_fifo && !fifo_empty && !tx_busy;

	// Command handling: launch from idle only, any other code stops work.
	wire cmd_launch = wr_cmd && bus.wdata == CMD_TRANSMIT && !tx_busy; // [R2]
	wire cmd_abort  = wr_cmd && bus.wdata != CMD_TRANSMIT && tx_busy;  // [R9] [R23]

	// Bit-period enable, running only while bits go out.
	wire on_air = state == ST_SOF || state == ST_DATA || state == ST_PAR || state == ST_EOF;
	wire bit_en = on_air && div_cnt == DIV_LAST; // [R25]

	// ************************************************************
	// Empty check points
	// ************************************************************
	// A write in the very cycle of the check still counts as data waiting.
	wire       empty_now = fifo_empty && !push; // [R22]
	wire [3:0] last_n    = {1'b0, bit_framing_config.tx_last_bit_count};
	// Truncated byte: check one bit before the last wanted bit, or at bit 0 for a one-bit byte.
	wire [3:0] trunc_chk = (last_n > 4'h1) ? last_n - 4'h2 : 4'h0; // [R21]
	// Parity adds one bit, so the check moves one bit later.
	wire [3:0] full_chk  = redundancy_config.parity_enable ? CHK_PARITY : CHK_NOPARITY; // [R20]
	wire       data_tick = bit_en && state == ST_DATA && !from_crc;
	wire       trunc_hit = data_tick && last_n != 4'h0 && pos == trunc_chk && !final_short;
	wire       full_hit  = data_tick && pos == full_chk && !final_short;
	// A one-bit final byte is judged at its only bit, so the marker must act at once.
	wire       short_now = final_short || (trunc_hit && empty_now);
	wire [3:0] byte_last = short_now ? last_n - 4'h1 : LAST_FULL; // [R14]
	wire       byte_end  = pos == byte_last;

	// Parity and CRC arithmetic.
	wire        par_bit  = (^cur_byte) ^ redundancy_config.parity_odd_select; // [R13]
	wire        crc_fb   = crc[0] ^ cur_byte[pos[2:0]];
	wire [15:0] crc_poly = redundancy_config.crc8 ? {8'h00, CRC8_POLY} : CRC16_POLY;
	wire [15:0] crc_init = redundancy_config.crc8 ? {8'h00, CRC8_PRESET} : CRC16_PRESET;
	wire [15:0] next_crc = {1'b0, crc[15:1]} ^ (crc_fb ? crc_poly : 16'h0000);

	// ************************************************************
	// Sequencer next state
	// ************************************************************
	logic tx_pop;
	logic ld_crc;
	logic ld_crc_hi;
	logic finish;
	logic emit;
	logic emit_val;
	logic after_byte;

	always_comb begin
		next_state = state;
		next_pos   = pos;
		tx_pop     = 1'b0;
		ld_crc     = 1'b0;
		ld_crc_hi  = 1'b0;
		finish     = 1'b0;
		emit       = 1'b0;
		emit_val   = 1'b0;
		after_byte = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (cmd_launch) begin
					next_state = ST_WAIT; // [R1]
				end
			end
			ST_WAIT: begin
				// Armed; the first byte in the FIFO starts the frame.
				if (!fifo_empty) begin
					next_state = ST_SOF; // [R4]
					next_pos   = '0;
				end
			end
			ST_SOF: begin
				if (bit_en) begin
					emit     = 1'b1;
					emit_val = SOF_LEVEL; // [R10]
					if (pos == SOF_LAST) begin
						next_state = ST_DATA;
						next_pos   = '0;
						tx_pop     = 1'b1;
					end else begin
						next_pos = pos + 4'h1;
					end
				end
			end
			ST_DATA: begin
				if (bit_en) begin
					emit     = 1'b1;
					emit_val = cur_byte[pos[2:0]];
					if (!byte_end) begin
						next_pos = pos + 4'h1;
					end else if (!short_now && redundancy_config.parity_enable) begin
						next_state = ST_PAR; // [R15]
					end else begin
						after_byte = 1'b1;
					end
				end
			end
			ST_PAR: begin
				if (bit_en) begin
					emit       = 1'b1;
					emit_val   = par_bit; // [R13]
					after_byte = 1'b1;
				end
			end
			ST_EOF: begin
				if (bit_en) begin
					if (pos == EOF_BITS) begin
						finish     = 1'b1;
						next_state = ST_IDLE; // [R7] [R24]
					end else begin
						emit     = 1'b1;
						emit_val = EOF_LEVEL; // [R10]
						next_pos = pos + 4'h1;
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase

		// Choose the source of the next byte once the current one is out.
		if (after_byte) begin
			next_pos = '0;
			if (from_crc) begin
				next_state = crc_hi_pend ? ST_DATA : ST_EOF;
				ld_crc_hi  = crc_hi_pend;
			end else if (short_now) begin
				next_state = ST_EOF; // [R14]
			end else if (accept_more) begin
				next_state = ST_DATA; // [R6] [R18]
				tx_pop     = 1'b1;
			end else if (redundancy_config.tx_crc_enable) begin
				next_state = ST_DATA; // [R12]
				ld_crc     = 1'b1;
			end else begin
				next_state = ST_EOF; // [R19]
			end
		end
	end

	// ************************************************************
	// Sequencer registers
	// ************************************************************
	// An abort wins over the next state and the bit timer; pos still takes its next value.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state   <= ST_IDLE;
			pos     <= '0;
			div_cnt <= '0;
		end else begin
			state   <= cmd_abort ? ST_IDLE : next_state; // [R9]
			pos     <= next_pos;
			div_cnt <= (on_air && !bit_en && !cmd_abort) ? div_cnt + 16'h0001 : 16'h0000;
		end
	end

	// Byte shifter source and the CRC byte bookkeeping.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cur_byte    <= '0;
			from_crc    <= 1'b0;
			crc_hi_pend <= 1'b0;
		end else begin
			if (tx_pop) begin
				cur_byte <= fifo_mem[rd_ptr];
			end else if (ld_crc) begin
				// Without parity the last data bit folds in during this very cycle.
				cur_byte <= data_tick ? next_crc[7:0] : crc[7:0];
			end else if (ld_crc_hi) begin
				cur_byte <= crc[15:8];
			end
			from_crc    <= !cmd_launch && (from_crc || ld_crc);
			crc_hi_pend <= ld_crc ? !redundancy_config.crc8 : (crc_hi_pend && !ld_crc_hi);
		end
	end

	// CRC runs over data bits only, never over parity or its own bytes.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			crc <= CRC16_PRESET;
		end else if (cmd_launch) begin
			crc <= crc_init;
		end else if (data_tick) begin
			crc <= next_crc; // [R12]
		end
	end

	// Accept-more and the truncated-final-byte marker.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			accept_more <= 1'b0;
			final_short <= 1'b0;
		end else begin
			if (cmd_launch) begin
				accept_more <= 1'b1;
			end else if (trunc_hit || full_hit) begin
				accept_more <= !empty_now; // [R21] [R22]
			end
			final_short <= !cmd_launch && !tx_pop && (final_short || (trunc_hit && empty_now));
		end
	end

	// Serial outputs hold each bit for one full bit period.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rf_data   <= 1'b0;
			rf_enable <= 1'b0;
		end else if (cmd_abort || finish) begin
			rf_data   <= 1'b0;
			rf_enable <= 1'b0;
		end else if (emit) begin
			rf_data   <= emit_val;
			rf_enable <= 1'b1;
		end
	end

	// ************************************************************
	// FIFO
	// ************************************************************
	always_ff @(posedge clk) begin
		if (push) begin
			fifo_mem[wr_ptr] <= bus.wdata;
		end
	end

	// Transmit pops and host pops never coincide, since host reads wait for idle.
	wire pop = tx_pop || host_pop;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr     <= '0;
			rd_ptr     <= '0;
			fifo_count <= '0;
		end else begin
			wr_ptr     <= push ? wr_ptr + 1'b1 : wr_ptr;
			rd_ptr     <= pop ? rd_ptr + 1'b1 : rd_ptr;
			fifo_count <= fifo_count + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

	// ************************************************************
	// Software registers
	// ************************************************************
	// Unsupported command codes are not kept; the register falls back to idle.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			command <= CMD_IDLE;
		end else if (cmd_launch) begin
			command <= CMD_TRANSMIT;
		end else if ((wr_cmd && bus.wdata != CMD_TRANSMIT) || finish) begin
			command <= CMD_IDLE; // [R23]
		end
	end

	// A host write to the framing register in the finish cycle wins.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			redundancy_config  <= cfts_redund_t'(REDUND_RST);
			bit_framing_config <= cfts_framing_t'(FRAMING_RST);
		end else begin
			if (wr_redund) begin
				redundancy_config <= cfts_redund_t'(bus.wdata);
			end
			if (wr_frm) begin
				bit_framing_config <= cfts_framing_t'(bus.wdata);
			end else if (finish) begin
				bit_framing_config <= cfts_framing_t'(FRAMING_RST); // [R16]
			end
			redundancy_config.rsvd  <= '0;
			bit_framing_config.rsvd <= '0;
		end
	end

	// Sticky flags, write one to clear; a new event beats a clear.
	wire [7:0] flag_clr = wr_flags ? bus.wdata : 8'h00;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flags <= '0;
		end else begin
			flags.tx_done_flag   <= finish || (flags.tx_done_flag && !flag_clr[0]);   // [R8]
			flags.idle_done_flag <= finish || (flags.idle_done_flag && !flag_clr[1]); // [R24]
			flags.rsvd           <= '0;
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	always_comb begin
		main_status_reg             = '0;
		main_status_reg.modem_phase = state; // [R11]
		main_status_reg.busy        = tx_busy;
		main_status_reg.fifo_full   = fifo_full;
		main_status_reg.fifo_empty  = fifo_empty;
	end

	wire [7:0] fifo_head = fifo_empty ? READ_ZERO : fifo_mem[rd_ptr];
	wire [7:0] level_rd  = 8'(fifo_count);
	wire [7:0] rd_mux    = (bus.addr == OFS_COMMAND)    ? command :
	                       (bus.addr == OFS_FIFO_PORT)  ? fifo_head :
	                       (bus.addr == OFS_STATUS)     ? main_status_reg :
	                       (bus.addr == OFS_FIFO_LEVEL) ? level_rd :
	                       (bus.addr == OFS_FLAGS)      ? flags :
	                       (bus.addr == OFS_FRAMING)    ? bit_framing_config :
	                       (bus.addr == OFS_REDUND)     ? redundancy_config : READ_ZERO;

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_data <= READ_ZERO;
		end else begin
			rd_data <= bus.rd ? rd_mux : READ_ZERO;
		end
	end

endmodule
`default_nettype wire
